// ---- hdl/epi_defines.svh ----
// register offsets, field positions, reset values and timing for the external pin interrupts
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
`define EPI_OFF_SENSE_CTRL 12'h000
`define EPI_OFF_SYS_STATUS 12'h004
`define EPI_OFF_ENABLE_CTRL 12'h008
`define EPI_OFF_FLAG 12'h00C
`define EPI_OFF_WAKE_CTRL 12'h010
`define EPI_OFF_PIN_STATUS 12'h014
`define EPI_RST_BYTE 8'h00
`define EPI_BIT_SENSE_A_LO 0
`define EPI_BIT_SENSE_A_HI 1
`define EPI_BIT_SENSE_B_LO 2
`define EPI_BIT_SENSE_B_HI 3
`define EPI_BIT_POL_C 6
`define EPI_BIT_EN_C 5
`define EPI_BIT_EN_A 6
`define EPI_BIT_EN_B 7
`define EPI_BIT_FLAG_C 5
`define EPI_BIT_FLAG_A 6
`define EPI_BIT_FLAG_B 7
`define EPI_BIT_WAKE_ARM 0
`define EPI_BIT_WAKE_BUF_OFF 1
`define EPI_MIN_PULSE_NS 50
`define EPI_CLK_PERIOD_NS 5
`define EPI_MIN_PULSE_CYC ((`EPI_MIN_PULSE_NS + `EPI_CLK_PERIOD_NS - 1) / `EPI_CLK_PERIOD_NS)
`define EPI_WAKE_SAMPLES 2
`define EPI_STARTUP_CYC 64
`endif

// ---- hdl/epi_pkg.sv ----
// types for the external pin interrupts
package epi_pkg;
  typedef enum logic [3:0] {
    EPI_SENSE_LOW = 4'h1,
    EPI_SENSE_CHANGE = 4'h2,
    EPI_SENSE_FALL = 4'h4,
    EPI_SENSE_RISE = 4'h8
  } epi_sense_t;
  typedef enum logic [2:0] {
    EPI_WK_IDLE = 3'h1,
    EPI_WK_START = 3'h2,
    EPI_WK_DONE = 3'h4
  } epi_wake_t;
endpackage

// ---- hdl/epi_pin_detect.sv ----
// per-pin synchroniser, sense decoder and edge detector
`timescale 1ns/1ps
`include "epi_defines.svh"
module epi_pin_detect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic [1:0] sense,
  output logic trig,
  output logic level_low,
  output logic pin_sync
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  epi_pkg::epi_sense_t mode;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  assign mode = (sense == 2'h0) ? epi_pkg::EPI_SENSE_LOW :
                (sense == 2'h1) ? epi_pkg::EPI_SENSE_CHANGE :
                (sense == 2'h2) ? epi_pkg::EPI_SENSE_FALL : epi_pkg::EPI_SENSE_RISE;
  wire rise = sync2_reg & ~prev_reg;
  wire fall = ~sync2_reg & prev_reg;
  // edge modes compare successive clocked samples only
  assign trig = (mode == epi_pkg::EPI_SENSE_CHANGE) ? (rise | fall) :
                (mode == epi_pkg::EPI_SENSE_FALL) ? fall :
                (mode == epi_pkg::EPI_SENSE_RISE) ? rise : 1'b0;
  assign level_low = (mode == epi_pkg::EPI_SENSE_LOW) & ~sync2_reg;
  assign pin_sync = sync2_reg;
  edge_after_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sense == 2'h3 && !$past(rst) && $rose(sync2_reg)) |-> trig)
    else $error("rising edge not detected");
endmodule

// ---- hdl/epi_top.sv ----
// external pin interrupt controller with ahb-lite registers
// How it works
// - pin activity requests interrupts even when the pin is driven as output.
// - low-level mode on pins a and b requests while pin stays low.
// - edge sensing needs clock; level and pin c edge work as wake sources.
// - wake level is sampled twice on the wake oscillator before accepted.
// - level gone before start-up end still wakes but raises no request.
// - pin b sense bits 3:2 select low, change, falling, rising.
// - pin a sense bits 1:0 select low, change, falling, rising.
// - pins a and b are sampled before edges; long pulses always detected.
// - pin c polarity bit 6: zero falling, one rising.
// - pin c edges latched asynchronously; here two ref_clk flops sample pin c instead; pulses over 50 ns guaranteed.
// - enable bit 7 gates pin b requests together with global enable.
// - enable bit 6 gates pin a requests together with global enable.
// - enable bit 5 gates pin c requests together with global enable.
// - each source has its own vector request and acknowledge.
// - flag bit 7 sets on pin b trigger, clears on service or write one.
// - pin b flag held clear in low-level mode.
// - flag bit 6 for pin a, same clearing, held clear in level mode.
// - flag bit 5 for pin c; buffer disable in sleep may set it.
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "epi_defines.svh"
module epi_top #(
  parameter int STARTUP_CYC = `EPI_STARTUP_CYC,
  parameter int PULSE_CYC = `EPI_MIN_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic ext_irq_c,
  input wire logic global_irq_en,
  input wire logic wdt_tick,
  input wire logic [2:0] vector_ack,
  output logic [2:0] vector_req,
  output logic wake_out
);
  logic [7:0] sense_ctrl_reg;
  logic [7:0] sys_status_reg;
  logic [7:0] enable_reg;
  logic [2:0] flag_reg;
  logic [2:0] flag_next;
  logic [1:0] wake_ctrl_reg;
  logic addr_wr_reg;
  logic addr_rd_reg;
  logic [11:0] addr_reg;
  logic [31:0] rdata_reg;
  logic c_sync1_reg;
  logic c_sync2_reg;
  logic [7:0] c_wide_cnt_reg;
  logic c_pol_prev_reg;
  logic c_buf_prev_reg;
  logic [1:0] wdt_samp_reg;
  logic [15:0] start_cnt_reg;
  epi_pkg::epi_wake_t wake_state_reg;
  epi_pkg::epi_wake_t wake_state_next;
  logic wake_pend_reg;

  // ahb-lite slave: zero wait states, always okay
  wire addr_phase = hsel & hready & htrans[1];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_wr_reg <= 1'b0;
      addr_rd_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else begin
      addr_wr_reg <= addr_phase & hwrite;
      addr_rd_reg <= addr_phase & ~hwrite;
      addr_reg <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire wr_sense = addr_wr_reg & (addr_reg == `EPI_OFF_SENSE_CTRL);
  wire wr_sys = addr_wr_reg & (addr_reg == `EPI_OFF_SYS_STATUS);
  wire wr_en = addr_wr_reg & (addr_reg == `EPI_OFF_ENABLE_CTRL);
  wire wr_flag = addr_wr_reg & (addr_reg == `EPI_OFF_FLAG);
  wire wr_wake = addr_wr_reg & (addr_reg == `EPI_OFF_WAKE_CTRL);

  // pins a and b each get their own instance of one detector module
  logic trig_a;
  logic trig_b;
  logic low_a;
  logic low_b;
  logic sync_a;
  logic sync_b;
  epi_pin_detect u_det_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(ext_irq_a),
    .sense(sense_ctrl_reg[`EPI_BIT_SENSE_A_HI:`EPI_BIT_SENSE_A_LO]),
    .trig(trig_a),
    .level_low(low_a),
    .pin_sync(sync_a)
  );
  epi_pin_detect u_det_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(ext_irq_b),
    .sense(sense_ctrl_reg[`EPI_BIT_SENSE_B_HI:`EPI_BIT_SENSE_B_LO]),
    .trig(trig_b),
    .level_low(low_b),
    .pin_sync(sync_b)
  );

  // pin c: single-clock model of the asynchronous edge latch; a level held
  // for the minimum pulse width is what is guaranteed to register
  wire pol_c = sys_status_reg[`EPI_BIT_POL_C];
  wire c_act = pol_c ? c_sync2_reg : ~c_sync2_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c_sync1_reg <= 1'b1;
      c_sync2_reg <= 1'b1;
      c_wide_cnt_reg <= 8'h00;
      c_pol_prev_reg <= 1'b0;
      c_buf_prev_reg <= 1'b0;
    end else begin
      c_sync1_reg <= ext_irq_c;
      c_sync2_reg <= c_sync1_reg;
      c_pol_prev_reg <= pol_c;
      c_buf_prev_reg <= wake_ctrl_reg[`EPI_BIT_WAKE_BUF_OFF];
      if (c_act && c_wide_cnt_reg != 8'hFF) begin
        c_wide_cnt_reg <= c_wide_cnt_reg + 8'h01;
      end else if (!c_act) begin
        c_wide_cnt_reg <= 8'h00;
      end
    end
  end
  // counting from the active edge means the request lands once the pulse
  // reaches its guaranteed width
  wire trig_c_edge = c_act & (c_wide_cnt_reg == 8'(PULSE_CYC - 1));
  // polarity change or input buffer cut can look like an edge
  wire trig_c_spur = (c_pol_prev_reg != pol_c) & c_act;
  wire trig_c_buf = wake_ctrl_reg[`EPI_BIT_WAKE_BUF_OFF] & ~c_buf_prev_reg
                    & ~enable_reg[`EPI_BIT_EN_C];
  wire trig_c = trig_c_edge | trig_c_spur | trig_c_buf;

  // flags: hardware set wins over write-one and acknowledge clears
  wire [2:0] trig_v = {trig_b, trig_a, trig_c};
  wire [2:0] lvl_mode = {sense_ctrl_reg[`EPI_BIT_SENSE_B_HI:`EPI_BIT_SENSE_B_LO] == 2'h0,
                         sense_ctrl_reg[`EPI_BIT_SENSE_A_HI:`EPI_BIT_SENSE_A_LO] == 2'h0,
                         1'b0};
  wire [2:0] wr_clr = wr_flag ? {hwdata[`EPI_BIT_FLAG_B], hwdata[`EPI_BIT_FLAG_A],
                                 hwdata[`EPI_BIT_FLAG_C]} : 3'h0;
  wire [2:0] en_v = {enable_reg[`EPI_BIT_EN_B], enable_reg[`EPI_BIT_EN_A],
                     enable_reg[`EPI_BIT_EN_C]};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flag
      assign flag_next[gi] = lvl_mode[gi] ? 1'b0 :
                             trig_v[gi] ? 1'b1 :
                             (wr_clr[gi] | vector_ack[gi]) ? 1'b0 : flag_reg[gi];
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_reg <= 3'h0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // separate vector lines; level mode requests straight from the synchronised pin
  wire [2:0] raw_req = {flag_reg[2] | low_b, flag_reg[1] | low_a, flag_reg[0]};
  assign vector_req = raw_req & en_v & {3{global_irq_en}};

  // control registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sense_ctrl_reg <= `EPI_RST_BYTE;
      sys_status_reg <= `EPI_RST_BYTE;
      enable_reg <= `EPI_RST_BYTE;
      wake_ctrl_reg <= 2'h0;
    end else begin
      if (wr_sense) begin
        sense_ctrl_reg <= hwdata[7:0];
      end
      if (wr_sys) begin
        sys_status_reg <= hwdata[7:0] & 8'h40;
      end
      if (wr_en) begin
        enable_reg <= hwdata[7:0] & 8'hE0;
      end
      if (wr_wake) begin
        wake_ctrl_reg <= hwdata[1:0];
      end
    end
  end

  // wake path: level on a or b, or pin c edge, while armed
  wire wake_lvl = (low_a & en_v[1]) | (low_b & en_v[2]);
  wire armed = wake_ctrl_reg[`EPI_BIT_WAKE_ARM];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wdt_samp_reg <= 2'h0;
    end else if (!armed || !wake_lvl) begin
      wdt_samp_reg <= 2'h0;
    end else if (wdt_tick && wdt_samp_reg != 2'(`EPI_WAKE_SAMPLES)) begin
      wdt_samp_reg <= wdt_samp_reg + 2'h1;
    end
  end
  wire lvl_valid = (wdt_samp_reg == 2'(`EPI_WAKE_SAMPLES));
  wire c_wake = armed & trig_c_edge & en_v[0];
  always_comb begin
    wake_state_next = wake_state_reg;
    case (wake_state_reg)
      epi_pkg::EPI_WK_IDLE: begin
        if (lvl_valid || c_wake) begin
          wake_state_next = epi_pkg::EPI_WK_START;
        end
      end
      epi_pkg::EPI_WK_START: begin
        if (start_cnt_reg == 16'(STARTUP_CYC - 1)) begin
          wake_state_next = epi_pkg::EPI_WK_DONE;
        end
      end
      epi_pkg::EPI_WK_DONE: begin
        if (!armed) begin
          wake_state_next = epi_pkg::EPI_WK_IDLE;
        end
      end
      default: begin
        wake_state_next = epi_pkg::EPI_WK_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_state_reg <= epi_pkg::EPI_WK_IDLE;
      start_cnt_reg <= 16'h0000;
      wake_pend_reg <= 1'b0;
    end else begin
      wake_state_reg <= wake_state_next;
      if (wake_state_reg == epi_pkg::EPI_WK_START) begin
        start_cnt_reg <= start_cnt_reg + 16'h0001;
      end else begin
        start_cnt_reg <= 16'h0000;
      end
      if (wake_state_reg == epi_pkg::EPI_WK_START && wake_state_next == epi_pkg::EPI_WK_DONE) begin
        // request survives only if level, pin c edge or pin c flag still there at start-up end
        wake_pend_reg <= wake_lvl | c_wake | flag_reg[0];
      end else if (wake_state_reg == epi_pkg::EPI_WK_IDLE) begin
        wake_pend_reg <= 1'b0;
      end
    end
  end
  // wake even if the level vanished; the request itself comes from vector_req
  assign wake_out = (wake_state_reg == epi_pkg::EPI_WK_DONE);

  // read mux
  wire [31:0] rd_mux =
    (addr_reg == `EPI_OFF_SENSE_CTRL) ? {24'h000000, sense_ctrl_reg} :
    (addr_reg == `EPI_OFF_SYS_STATUS) ? {24'h000000, sys_status_reg} :
    (addr_reg == `EPI_OFF_ENABLE_CTRL) ? {24'h000000, enable_reg} :
    (addr_reg == `EPI_OFF_FLAG) ? {24'h000000, flag_reg[2], flag_reg[1], flag_reg[0], 5'h00} :
    (addr_reg == `EPI_OFF_WAKE_CTRL) ? {30'h00000000, wake_ctrl_reg} :
    (addr_reg == `EPI_OFF_PIN_STATUS) ? {27'h0000000, wake_pend_reg, wake_out,
                                         c_sync2_reg, sync_b, sync_a} : 32'h00000000;
  assign hrdata = addr_rd_reg ? rd_mux : 32'h00000000;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rd_mux;
    end
  end

  sequence s_flag_trig_b;
    trig_b && !lvl_mode[2];
  endsequence
  flag_b_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_flag_trig_b |=> flag_reg[2])
    else $error("flag b not set");
  flag_b_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    lvl_mode[2] |=> !flag_reg[2] || !$past(lvl_mode[2]))
    else $error("flag b set in level mode");
  flag_a_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (trig_a && !lvl_mode[1]) |=> flag_reg[1])
    else $error("flag a not set");
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_flag && hwdata[`EPI_BIT_FLAG_C] == 1'b0 && !vector_ack[0]) |=>
      flag_reg[0] == $past(flag_reg[0]) || flag_reg[0])
    else $error("flag c cleared by zero write");
  req_gate_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    vector_req[2] |-> (global_irq_en && enable_reg[`EPI_BIT_EN_B]))
    else $error("b request without enables");
  req_gate_a_a: assert property (@(posedge ref_clk) disable iff (rst)
    vector_req[1] |-> (global_irq_en && enable_reg[`EPI_BIT_EN_A]))
    else $error("a request without enables");
  req_gate_c_a: assert property (@(posedge ref_clk) disable iff (rst)
    (flag_reg[0] && global_irq_en && enable_reg[`EPI_BIT_EN_C]) |-> vector_req[0])
    else $error("c request missing");
  level_req_a: assert property (@(posedge ref_clk) disable iff (rst)
    (low_a && en_v[1] && global_irq_en) |-> vector_req[1])
    else $error("level request missing");
  pulse_c_a: assert property (@(posedge ref_clk) disable iff (rst)
    (c_act && c_wide_cnt_reg == 8'(PULSE_CYC - 1) && !lvl_mode[0]) |=> flag_reg[0])
    else $error("wide c pulse lost");
  wake_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wake_state_reg == epi_pkg::EPI_WK_IDLE && lvl_valid) |=>
      wake_state_reg == epi_pkg::EPI_WK_START)
    else $error("validated level did not start wake");
endmodule

// ---- testbench/epi_pin_source.sv ----
// model of the external sources that drive the three interrupt pins
`timescale 1ns/1ps
module epi_pin_source (
  input wire logic ref_clk,
  output logic [2:0] pins
);
  // pins idle high as if pulled up, so a released source never shows a stale low
  initial pins = 3'h7;
  // a level is held for whole clock periods, never shorter than the caller asks
  task automatic hold(input int idx, input logic v, input int n);
    pins[idx] <= v;
    repeat (n) @(posedge ref_clk);
  endtask
endmodule

// ---- testbench/external_pin_interrupts_tb_top.sv ----
// self-checking bench for the external pin interrupt controller
`timescale 1ns/1ps
`include "epi_defines.svh"
module external_pin_interrupts_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic global_irq_en = 1'b0;
  logic wdt_tick = 1'b0;
  logic [2:0] vector_ack = 3'h0;
  logic [2:0] vector_req;
  logic wake_out;
  logic [2:0] pins;
  logic rd_dp = 1'b0;
  logic [31:0] qe[$];
  logic [31:0] qm[$];
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 93;
  int m;
  int p;
  int sh;
  int fb;
  always #2.5 ref_clk = ~ref_clk;
  epi_pin_source src (.ref_clk(ref_clk), .pins(pins));
  // short start-up count keeps the wake scenario brief
  epi_top #(.STARTUP_CYC(4)) DUT (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .ext_irq_a(pins[0]), .ext_irq_b(pins[1]), .ext_irq_c(pins[2]),
    .global_irq_en(global_irq_en), .wdt_tick(wdt_tick), .vector_ack(vector_ack),
    .vector_req(vector_req), .wake_out(wake_out)
  );
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // the watcher takes read data at the edge that ends the data phase
  always @(posedge ref_clk) begin
    if (rd_dp) begin
      cmp("hrdata", qe.pop_front(), hrdata & qm.pop_front());
    end
    rd_dp <= !rst && hsel && hreadyout && htrans[1] && !hwrite;
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
    qe.push_back(e & mk);
    qm.push_back(mk);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic vec(input logic [2:0] e);
    cmp("vector_req", {29'h0, e}, {29'h0, vector_req});
  endtask
  initial begin
    w(2);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`EPI_OFF_SENSE_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(`EPI_OFF_SYS_STATUS, 32'h0, 32'hFFFFFFFF);
    rd(`EPI_OFF_ENABLE_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(`EPI_OFF_FLAG, 32'h0, 32'hFFFFFFFF);
    rd(12'h020, 32'h0, 32'hFFFFFFFF);
    global_irq_en <= 1'b1;
    wr(`EPI_OFF_ENABLE_CTRL, 8'hE0);
    rd(`EPI_OFF_ENABLE_CTRL, 32'hE0, 32'hE0);
    // change, falling and rising sense on pins a and b, flag checked after each edge
    for (p = 0; p < 2; p++) begin
      sh = 2 * p;
      fb = 6 + p;
      for (m = 1; m < 4; m++) begin
        wr(`EPI_OFF_SENSE_CTRL, 8'(m << sh));
        wr(`EPI_OFF_FLAG, 8'hE0);
        src.hold(p, 1'b0, 8);
        rd(`EPI_OFF_FLAG, 32'((m != 3) << fb), 32'h1 << fb);
        vec(3'((m != 3) << (p + 1)));
        wr(`EPI_OFF_FLAG, 8'(1 << fb));
        src.hold(p, 1'b1, 8);
        rd(`EPI_OFF_FLAG, 32'((m != 2) << fb), 32'h1 << fb);
      end
    end
    // low level on pin a: request follows the pin, flag stays clear
    wr(`EPI_OFF_SENSE_CTRL, 8'h0C);
    wr(`EPI_OFF_FLAG, 8'hE0);
    src.hold(0, 1'b0, 8);
    vec(3'h2);
    rd(`EPI_OFF_FLAG, 32'h0, 32'h40);
    global_irq_en <= 1'b0;
    w(1);
    vec(3'h0);
    global_irq_en <= 1'b1;
    wr(`EPI_OFF_ENABLE_CTRL, 8'hA0);
    w(1);
    vec(3'h0);
    wr(`EPI_OFF_ENABLE_CTRL, 8'hE0);
    src.hold(0, 1'b1, 8);
    vec(3'h0);
    // writing zero keeps the flag, the handler acknowledge clears it
    wr(`EPI_OFF_SENSE_CTRL, 8'h02);
    src.hold(0, 1'b0, 8);
    src.hold(0, 1'b1, 8);
    wr(`EPI_OFF_FLAG, 8'h00);
    rd(`EPI_OFF_FLAG, 32'h40, 32'hE0);
    vector_ack <= 3'h2;
    w(1);
    vector_ack <= 3'h0;
    w(1);
    rd(`EPI_OFF_FLAG, 32'h0, 32'hE0);
    // pin c for each polarity, changed in the safe order
    for (p = 0; p < 2; p++) begin
      wr(`EPI_OFF_ENABLE_CTRL, 8'hC0);
      wr(`EPI_OFF_SYS_STATUS, 8'(p << 6));
      // a level already active under the new polarity may still raise the flag
      w(16);
      wr(`EPI_OFF_FLAG, 8'h20);
      wr(`EPI_OFF_ENABLE_CTRL, 8'hE0);
      src.hold(2, 1'b0, 16);
      rd(`EPI_OFF_FLAG, 32'((p == 0) << 5), 32'h20);
      wr(`EPI_OFF_FLAG, 8'h20);
      src.hold(2, 1'b1, 16);
      rd(`EPI_OFF_FLAG, 32'((p == 1) << 5), 32'h20);
      vec(3'(p == 1));
    end
    // random pulse widths of two clocks or more on pin b in change mode
    wr(`EPI_OFF_SENSE_CTRL, 8'h04);
    repeat (6) begin
      wr(`EPI_OFF_FLAG, 8'hE0);
      src.hold(1, 1'b0, 2 + ($random(seed) & 7));
      src.hold(1, 1'b1, 8);
      rd(`EPI_OFF_FLAG, 32'h80, 32'h80);
    end
    // wake needs two watchdog samples of the level, then the start-up count
    wr(`EPI_OFF_SENSE_CTRL, 8'h00);
    wr(`EPI_OFF_ENABLE_CTRL, 8'h40);
    wr(`EPI_OFF_WAKE_CTRL, 8'h01);
    src.hold(0, 1'b0, 4);
    wdt_tick <= 1'b1;
    w(1);
    wdt_tick <= 1'b0;
    w(3);
    cmp("wake_out", 32'h0, {31'h0, wake_out});
    wdt_tick <= 1'b1;
    w(1);
    wdt_tick <= 1'b0;
    w(12);
    cmp("wake_out", 32'h1, {31'h0, wake_out});
    rd(`EPI_OFF_PIN_STATUS, 32'h1E, 32'h1F);
    wr(`EPI_OFF_WAKE_CTRL, 8'h00);
    src.hold(0, 1'b1, 4);
    w(2);
    tally_and_finish();
  end
endmodule
